// ### common/prcg_pkg.sv
/*
  Constants, types and helpers of the peripheral reset and clock-gate
  controller: register byte addresses, reset values, write masks, bit
  positions, reset pulse timing and pulse generator states.
  Assumes a 25 MHz system clock and APB access with 32-bit data.
*/
// Notes on behaviour
// - Bit 7 stops low-speed compute-memory clock
// - Bit 6 stops boot, keypad, pwm, gpio clocks
// - Bits 5,4,2,1,0 each gate one unit
// - Gate register resets 0xffff_ff3e, reserved read ones
// - Software asserts and releases peripheral resets
// - Bit 31 pulses global reset, reads zero
// - Global pulse resets chip like external reset
// - Bit 20 pulses bus interface reset, reads zero
// - Other bits hold reset until written zero
// - Gated unit stays disabled until bit clears
package prcg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_CTRL_ADDR  = 32'hd003_0018;
  localparam logic [31:0] GATE2_ADDR     = 32'hd003_00cc;
  localparam logic [31:0] RST_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] GATE2_RESET    = 32'hffff_ff3e;
  localparam logic [31:0] GATE2_WR_MASK  = 32'h0000_00f7;
  localparam logic [31:0] RST_HOLD_MASK  = 32'h7fef_ffff;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Bit positions
  // ----------------------------------------------------------------
  localparam int GLOBAL_RST_BIT = 31;
  localparam int EBI_RST_BIT    = 20;
  localparam int CMEM_LS_BIT    = 7;
  localparam int SYS_GRP_BIT    = 6;
  localparam int RAND2_BIT      = 5;
  localparam int TCM_BIT        = 4;
  localparam int SBIST_BIT      = 2;
  localparam int UART2_BIT      = 1;
  localparam int AUX_CPU_BIT    = 0;
  localparam int PERIPH_RST_W   = 31;

  // ----------------------------------------------------------------
  // Reset pulse timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int GLOBAL_PULSE_NS = 400;
  localparam int EBI_PULSE_NS    = 200;
  localparam int PULSE_CNT_W     = 8;

  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cycles

  localparam int GLOBAL_PULSE_CYC = min_cycles(GLOBAL_PULSE_NS);
  localparam int EBI_PULSE_CYC    = min_cycles(EBI_PULSE_NS);

  typedef enum logic [1:0] {
    PG_IDLE    = 2'b00,
    PG_ACTIVE  = 2'b01,
    PG_RECOVER = 2'b11
  } prcg_pulse_state_t;

  // Byte-lane merge of a write into a register, writable bits only
  function automatic logic [31:0] byte_merge(input logic [31:0] old_val,
                                             input logic [31:0] wr_val,
                                             input logic [3:0]  strb,
                                             input logic [31:0] wmask);
    logic [31:0] lane;
    lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_val & ~(lane & wmask)) | (wr_val & lane & wmask);
  endfunction : byte_merge

endpackage : prcg_pkg

// ### core/prcg_pulse_gen.sv
/*
  Fixed-length reset pulse generator.
  Assumes fire_in is a one-cycle request from logic on clk_in.
*/
`timescale 1ns/100ps
`default_nettype none
module prcg_pulse_gen
  import prcg_pkg::*;
#(
  parameter int PULSE_CYC = 1
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic fire_in,
  output var  logic pulse_out,
  output var  logic busy_out
);

  localparam logic [PULSE_CNT_W-1:0] LAST_CNT = PULSE_CNT_W'(PULSE_CYC - 1);
  localparam logic [PULSE_CNT_W-1:0] CNT_ZERO = '0;

  prcg_pulse_state_t        state_r;
  logic [PULSE_CNT_W-1:0]   cnt_r;

  // Requests during a pulse are dropped; a pulse is never stretched
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= PG_IDLE;
      cnt_r   <= CNT_ZERO;
    end else begin
      case (state_r)
        PG_IDLE: begin
          cnt_r <= CNT_ZERO;
          if (fire_in) begin
            state_r <= PG_ACTIVE;
          end
        end
        PG_ACTIVE: begin
          if (cnt_r == LAST_CNT) begin
            state_r <= PG_RECOVER;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        PG_RECOVER: begin
          state_r <= PG_IDLE;
        end
        default: begin
          state_r <= PG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_out <= 1'b0;
      busy_out  <= 1'b0;
    end else begin
      pulse_out <= (state_r == PG_IDLE && fire_in) ||
                   (state_r == PG_ACTIVE && cnt_r != LAST_CNT);
      busy_out  <= (state_r != PG_IDLE) || fire_in;
    end
  end

endmodule : prcg_pulse_gen
`default_nettype wire

// ### core/prcg_top.sv
/*
  Peripheral reset and clock-gate controller: second clock-gate register
  and main peripheral reset register behind an APB slave; registered
  clock-gate outputs, held reset outputs and two reset pulses.
  Assumes every gate output feeds a latch-based clock-gating cell in the
  target unit and that the global reset output is merged into the
  chip reset tree.
*/
`timescale 1ns/100ps
`default_nettype none
module prcg_top
  import prcg_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  // APB slave
  input  wire logic                    psel_in,
  input  wire logic                    penable_in,
  input  wire logic                    pwrite_in,
  input  wire logic [31:0]             paddr_in,
  input  wire logic [31:0]             pwdata_in,
  input  wire logic [3:0]              pstrb_in,
  output var  logic [31:0]             prdata_out,
  output var  logic                    pready_out,
  output var  logic                    pslverr_out,
  // Clock gates, high while the unit's clock is stopped
  output var  logic                    cmem_ls_clk_gate_out,
  output var  logic                    boot_loader_clk_gate_out,
  output var  logic                    keypad_clk_gate_out,
  output var  logic                    pwm_clk_gate_out,
  output var  logic                    gpio_clk_gate_out,
  output var  logic                    secondary_random_unit_gate_out,
  output var  logic                    tcm_clk_gate_out,
  output var  logic                    selftest_clk_gate_out,
  output var  logic                    second_serial_port_gate_out,
  output var  logic                    aux_cpu_clock_gate_out,
  // Resets, high while the peripheral is in reset
  output var  logic [PERIPH_RST_W-1:0] periph_reset_out,
  output var  logic                    global_reset_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] gate2_r;
  logic [31:0] gate2_nxt;
  logic [31:0] rst_hold_r;
  logic [31:0] rst_hold_nxt;
  logic        hit_gate2;
  logic        hit_rst;
  logic        hit_any;
  logic        acc_done;
  logic        wr_done;
  logic        fire_global;
  logic        fire_ebi;
  logic        global_pulse;
  logic        global_busy;
  logic        ebi_pulse;
  logic        ebi_busy;
  logic [31:0] rd_word;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign hit_gate2 = (paddr_in == GATE2_ADDR);
  assign hit_rst   = (paddr_in == RST_CTRL_ADDR);
  assign hit_any   = hit_gate2 || hit_rst;

  // Access completes on the edge that sees pready high
  assign acc_done  = psel_in && penable_in && pready_out;
  assign wr_done   = acc_done && pwrite_in && hit_any;

  // ----------------------------------------------------------------
  // APB handshake, one wait state in every access
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= psel_in && penable_in && !pready_out;
    end
  end

  // Unmapped addresses answer with an error and change nothing
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= psel_in && penable_in && !pready_out && !hit_any;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = ZERO_WORD;
    if (hit_gate2) begin
      rd_word = gate2_r;
    end else if (hit_rst) begin
      rd_word = rst_hold_r & RST_HOLD_MASK;
    end
  end

  // Sampled with pready so data stands for the whole ready cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out <= ZERO_WORD;
    end else if (psel_in && penable_in && !pready_out && !pwrite_in) begin
      prdata_out <= rd_word;
    end else if (acc_done) begin
      prdata_out <= ZERO_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Second clock-gate register
  // ----------------------------------------------------------------
  always_comb begin
    gate2_nxt = gate2_r;
    if (wr_done && hit_gate2) begin
      // Reserved bits are outside the mask and keep their ones
      gate2_nxt = byte_merge(gate2_r, pwdata_in, pstrb_in, GATE2_WR_MASK);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gate2_r <= GATE2_RESET;
    end else begin
      gate2_r <= gate2_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral reset register
  // ----------------------------------------------------------------
  always_comb begin
    rst_hold_nxt = rst_hold_r;
    if (wr_done && hit_rst) begin
      // Pulse bits are masked out so they never store a one
      rst_hold_nxt = byte_merge(rst_hold_r, pwdata_in, pstrb_in, RST_HOLD_MASK);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_hold_r <= RST_CTRL_RESET;
    end else begin
      rst_hold_r <= rst_hold_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pulse requests
  // ----------------------------------------------------------------
  assign fire_global = wr_done && hit_rst && pstrb_in[3] &&
                       pwdata_in[GLOBAL_RST_BIT];
  assign fire_ebi    = wr_done && hit_rst && pstrb_in[2] &&
                       pwdata_in[EBI_RST_BIT];

  prcg_pulse_gen #(
    .PULSE_CYC (GLOBAL_PULSE_CYC)
  ) u_global_pulse (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .fire_in   (fire_global),
    .pulse_out (global_pulse),
    .busy_out  (global_busy)
  );

  prcg_pulse_gen #(
    .PULSE_CYC (EBI_PULSE_CYC)
  ) u_ebi_pulse (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .fire_in   (fire_ebi),
    .pulse_out (ebi_pulse),
    .busy_out  (ebi_busy)
  );

  // ----------------------------------------------------------------
  // Global reset output
  // ----------------------------------------------------------------
  // If fed back into rst_in this pulse also clears this block;
  // the reset tree must stretch it, the block cannot after its own reset.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      global_reset_out <= 1'b0;
    end else begin
      global_reset_out <= global_pulse && global_busy;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral reset outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      periph_reset_out <= RST_CTRL_RESET[PERIPH_RST_W-1:0];
    end else begin
      periph_reset_out <= rst_hold_r[PERIPH_RST_W-1:0];
      periph_reset_out[EBI_RST_BIT] <= ebi_pulse && ebi_busy;
    end
  end

  // ----------------------------------------------------------------
  // Clock-gate outputs
  // ----------------------------------------------------------------
  // Gates change only on the rising edge; the unit's latch-based cell
  // picks them up while its clock is low, so no pulse is cut short.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cmem_ls_clk_gate_out <= GATE2_RESET[CMEM_LS_BIT];
    end else begin
      cmem_ls_clk_gate_out <= gate2_r[CMEM_LS_BIT];
    end
  end

  // ----------------------------------------------------------------
  // System group clock gates
  // ----------------------------------------------------------------
  // One bit stops the whole group; a flop per output keeps each
  // unit's gate local to its own clock cell.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      boot_loader_clk_gate_out <= GATE2_RESET[SYS_GRP_BIT];
    end else begin
      boot_loader_clk_gate_out <= gate2_r[SYS_GRP_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      keypad_clk_gate_out <= GATE2_RESET[SYS_GRP_BIT];
    end else begin
      keypad_clk_gate_out <= gate2_r[SYS_GRP_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pwm_clk_gate_out <= GATE2_RESET[SYS_GRP_BIT];
    end else begin
      pwm_clk_gate_out <= gate2_r[SYS_GRP_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      gpio_clk_gate_out <= GATE2_RESET[SYS_GRP_BIT];
    end else begin
      gpio_clk_gate_out <= gate2_r[SYS_GRP_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Single-unit clock gates
  // ----------------------------------------------------------------
  // Unit stays gated, hence disabled, until software clears the bit.
  // Reset leaves the aux cpu clock running and the other units stopped.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      secondary_random_unit_gate_out <= GATE2_RESET[RAND2_BIT];
    end else begin
      secondary_random_unit_gate_out <= gate2_r[RAND2_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tcm_clk_gate_out <= GATE2_RESET[TCM_BIT];
    end else begin
      tcm_clk_gate_out <= gate2_r[TCM_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      selftest_clk_gate_out <= GATE2_RESET[SBIST_BIT];
    end else begin
      selftest_clk_gate_out <= gate2_r[SBIST_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      second_serial_port_gate_out <= GATE2_RESET[UART2_BIT];
    end else begin
      second_serial_port_gate_out <= gate2_r[UART2_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      aux_cpu_clock_gate_out <= GATE2_RESET[AUX_CPU_BIT];
    end else begin
      aux_cpu_clock_gate_out <= gate2_r[AUX_CPU_BIT];
    end
  end

endmodule : prcg_top
`default_nettype wire

// ### tb/prcg_periph_model.sv
/*
  Behavioural unit behind one clock gate: latch-based gating cell and a tick counter.
  Assumes gate_in is high while the unit's clock must stop.
*/
`timescale 1ns/100ps
`default_nettype none
module prcg_periph_model (
  input  wire logic        clk_in,
  input  wire logic        gate_in,
  input  wire logic        unit_rst_in,
  output var  logic [15:0] tick_cnt_out
);
  logic en_lat;
  logic gclk;
  // Latch in low phase so no clock pulse is shortened
  always_latch if (!clk_in) en_lat = !gate_in;
  assign gclk = clk_in & en_lat;
  always_ff @(posedge gclk or posedge unit_rst_in) begin
    if (unit_rst_in) tick_cnt_out <= 16'h0000;
    else tick_cnt_out <= tick_cnt_out + 16'h0001;
  end
endmodule : prcg_periph_model
`default_nettype wire

// ### tb/prcg_asserts.sv
/*
  Port checker of prcg_top.
  Assumes it is bound onto prcg_top and sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module prcg_asserts
  import prcg_pkg::*;
(
  input wire logic                    clk_in,
  input wire logic                    rst_in,
  input wire logic                    psel_in,
  input wire logic                    penable_in,
  input wire logic                    pwrite_in,
  input wire logic [31:0]             paddr_in,
  input wire logic [31:0]             pwdata_in,
  input wire logic [3:0]              pstrb_in,
  input wire logic [31:0]             prdata_out,
  input wire logic                    pready_out,
  input wire logic                    pslverr_out,
  input wire logic                    cmem_ls_clk_gate_out,
  input wire logic                    aux_cpu_clock_gate_out,
  input wire logic [PERIPH_RST_W-1:0] periph_reset_out,
  input wire logic                    global_reset_out
);
  logic hit;
  logic wr_gate;
  logic wr_rst;
  assign hit     = psel_in & penable_in & pready_out & pwrite_in;
  assign wr_gate = hit & (paddr_in == GATE2_ADDR);
  assign wr_rst  = hit & (paddr_in == RST_CTRL_ADDR);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("ready held");
  one_wait_a: assert property ($rose(penable_in) && psel_in |=> pready_out) else $error("ready late");
  unmapped_err_a: assert property (pready_out && paddr_in != GATE2_ADDR && paddr_in != RST_CTRL_ADDR
    |-> pslverr_out) else $error("no error on unmapped");
  idle_rdata_a: assert property (!pready_out |-> prdata_out == ZERO_WORD) else $error("stray read data");
  pulse_bits_a: assert property (pready_out && !pwrite_in && paddr_in == RST_CTRL_ADDR
    |-> !prdata_out[31] && !prdata_out[20]) else $error("pulse bit read one");
  aux_gate_a: assert property (wr_gate && pstrb_in[0]
    |=> ##1 aux_cpu_clock_gate_out == $past(pwdata_in[0], 2)) else $error("aux gate wrong");
  cmem_hold_a: assert property (!$past(wr_gate, 2) |-> $stable(cmem_ls_clk_gate_out))
    else $error("cmem gate moved");
  held_rst_a: assert property (wr_rst && pstrb_in[0]
    |=> ##1 periph_reset_out[0] == $past(pwdata_in[0], 2)) else $error("held reset wrong");
  global_len_a: assert property ($rose(global_reset_out)
    |-> global_reset_out[*8] ##1 global_reset_out ##1 global_reset_out ##1 !global_reset_out)
    else $error("global pulse length");
  global_cause_a: assert property ($rose(global_reset_out)
    |-> $past(wr_rst & pwdata_in[31] & pstrb_in[3], 2)) else $error("global pulse uncaused");
  ebi_len_a: assert property ($rose(periph_reset_out[20])
    |-> periph_reset_out[20][*5] ##1 !periph_reset_out[20]) else $error("bus reset pulse length");
endmodule : prcg_asserts

bind prcg_top prcg_asserts prcg_asserts_i (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .cmem_ls_clk_gate_out(cmem_ls_clk_gate_out), .aux_cpu_clock_gate_out(aux_cpu_clock_gate_out),
  .periph_reset_out(periph_reset_out), .global_reset_out(global_reset_out));
`default_nettype wire

// ### tb/prcg_top_tb_top.sv
/*
  Register-level testbench of prcg_top over APB.
  Assumes the checker is bound in and the unit model sits on the aux cpu gate.
*/
`timescale 1ns/100ps
`default_nettype none
module prcg_top_tb_top
  import prcg_pkg::*;
;
  logic        clk_in = 1'b0, rst_in = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [3:0]  pstrb = '0;
  logic        pready, pslverr, er, g7, gb, gk, gp, gg, g5, g4, g2, g1, g0, glob;
  logic [30:0] prst;
  logic [15:0] tick, t0;
  int          n_mismatch = 0, checked = 0, cyc = 0, ng, ne;

  always #20 clk_in = ~clk_in;

  prcg_top prcg_top_i (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .cmem_ls_clk_gate_out(g7),
    .boot_loader_clk_gate_out(gb), .keypad_clk_gate_out(gk), .pwm_clk_gate_out(gp),
    .gpio_clk_gate_out(gg), .secondary_random_unit_gate_out(g5), .tcm_clk_gate_out(g4),
    .selftest_clk_gate_out(g2), .second_serial_port_gate_out(g1), .aux_cpu_clock_gate_out(g0),
    .periph_reset_out(prst), .global_reset_out(glob));
  // Bench reset also clears the unit, else its counter starts unknown
  prcg_periph_model prcg_periph_model_i (.clk_in(clk_in), .gate_in(g0), .unit_rst_in(rst_in | prst[0]),
    .tick_cnt_out(tick));

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Starts one edge late so a release is never overwritten in its own step
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r, output logic e);
    @(posedge clk_in);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk_in);
    pen <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb

  // Counts the high cycles of both pulses right after the pulse write
  task automatic count_pulses(output int cg, output int ce);
    cg = 0; ce = 0;
    repeat (30) begin
      @(negedge clk_in);
      cg += glob; ce += prst[20];
    end
  endtask : count_pulses

  // System group packed into bit 6 (AND) and bit 3 (OR) so all four must agree
  function automatic logic [7:0] gates();
    return {g7, gb & gk & gp & gg, g5, g4, gb | gk | gp | gg, g2, g1, g0};
  endfunction : gates

  function automatic logic [7:0] exp_gate(input logic [7:0] v);
    return {v[7:4], v[6], v[2:0]};
  endfunction : exp_gate

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Timeout and tests
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    apb(1'b0, GATE2_ADDR, '0, 4'h0, rd, er);
    chk("gate_reset", rd, 32'hffff_ff3e);
    chk("gate_outs", gates(), exp_gate(8'h3e));
    apb(1'b0, RST_CTRL_ADDR, '0, 4'h0, rd, er);
    chk("rst_reset", rd, 32'h0000_0000);
    chk("rst_outs", prst, 31'h0000_0000);
    @(negedge clk_in) t0 = tick;
    repeat (4) @(negedge clk_in);
    chk("reset_ticks", tick - t0, 16'h0004);
    $display("test reset done");
    for (int b = 0; b < 8; b++) begin
      apb(1'b1, GATE2_ADDR, 32'h1 << b, 4'hf, rd, er);
      apb(1'b0, GATE2_ADDR, '0, 4'h0, rd, er);
      chk("gate_read", rd, 32'hffff_ff08 | (32'h1 << b));
      chk("gate_bit", gates(), exp_gate(8'h1 << b));
    end
    apb(1'b1, GATE2_ADDR, 32'h0000_0001, 4'h1, rd, er);
    apb(1'b1, GATE2_ADDR, 32'h0000_00ff, 4'he, rd, er);
    apb(1'b0, GATE2_ADDR, '0, 4'h0, rd, er);
    chk("gate_strobe", rd, 32'hffff_ff09);
    @(negedge clk_in) t0 = tick;
    repeat (4) @(negedge clk_in);
    chk("gated_ticks", tick - t0, 16'h0000);
    apb(1'b1, GATE2_ADDR, '0, 4'hf, rd, er);
    repeat (3) @(posedge clk_in);
    @(negedge clk_in) t0 = tick;
    repeat (4) @(negedge clk_in);
    chk("ungated_ticks", tick - t0, 16'h0004);
    $display("test gates done");
    for (int i = 0; i < 31; i++) begin
      if (i != 20) begin
        apb(1'b1, RST_CTRL_ADDR, 32'h1 << i, 4'hf, rd, er);
        apb(1'b0, RST_CTRL_ADDR, '0, 4'h0, rd, er);
        chk("hold_read", rd, 32'h1 << i);
        chk("hold_out", prst, 31'h1 << i);
      end
    end
    $display("test held resets done");
    apb(1'b1, RST_CTRL_ADDR, 32'h0010_0001, 4'hf, rd, er);
    count_pulses(ng, ne);
    chk("bus_pulse", ne, EBI_PULSE_CYC);
    chk("bus_no_global", ng, 0);
    apb(1'b1, RST_CTRL_ADDR, 32'h8000_0001, 4'hf, rd, er);
    count_pulses(ng, ne);
    chk("global_pulse", ng, GLOBAL_PULSE_CYC);
    chk("global_no_bus", ne, 0);
    apb(1'b0, RST_CTRL_ADDR, '0, 4'h0, rd, er);
    chk("pulse_reads", rd, 32'h0000_0001);
    apb(1'b1, RST_CTRL_ADDR, 32'h8010_0000, 4'h3, rd, er);
    count_pulses(ng, ne);
    chk("no_strobe_pulse", ng, 0);
    chk("no_strobe_bus", ne, 0);
    chk("held_cleared", prst, 31'h0000_0000);
    $display("test pulses done");
    apb(1'b1, 32'hd003_001c, 32'h0, 4'hf, rd, er);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_data", rd, 32'h0);
    apb(1'b0, GATE2_ADDR, '0, 4'h0, rd, er);
    chk("gate_kept", rd, 32'hffff_ff08);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule : prcg_top_tb_top
`default_nettype wire
